// [design/spsa_pkg.sv]
package spsa_pkg;
   // Mode field encoding for slave with slave-select control.
   localparam logic [3:0] SPSA_MODE_SLAVE_SS = 4'h4;
   // Mode field encoding for slave without slave-select control.
   localparam logic [3:0] SPSA_MODE_SLAVE    = 4'h5;
   // Bits per serial byte.
   localparam int         SPSA_BYTE_BITS     = 8;
   // Width of the rate reload field used for Start timing.
   localparam int         SPSA_RATE_W        = 7;
   // Reset values.
   localparam logic [7:0] SPSA_SHIFT_RST     = 8'h00;
   localparam logic [2:0] SPSA_CNT_RST       = 3'h0;
   localparam logic [6:0] SPSA_RATE_RST      = 7'h00;
   // Start generator states.
   typedef enum logic [1:0] {
      SPSA_ST_IDLE  = 2'b00,
      SPSA_ST_CNT1  = 2'b01,
      SPSA_ST_CNT2  = 2'b10
   } spsa_start_t;
endpackage

// [design/spsa_start_gen.sv]
`timescale 1ns/1ps
// Start condition generator with collision detection.
module spsa_start_gen
   import spsa_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   start_req,
   input  wire logic [SPSA_RATE_W-1:0] rate_reload_reg,
   input  wire logic                   sda_in,
   input  wire logic                   scl_in,
   output logic                        sda_low_q,
   output logic                        scl_low_q,
   output logic                        start_done_q,
   output logic                        collision_q
);
   spsa_start_t            st_q;
   logic [SPSA_RATE_W-1:0] rate_counter_q;

   // One process holds the whole sequence; each branch follows one phase.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q           <= SPSA_ST_IDLE;
         rate_counter_q <= SPSA_RATE_RST;
         sda_low_q      <= 1'b0;
         scl_low_q      <= 1'b0;
         start_done_q   <= 1'b0;
         collision_q    <= 1'b0;
      end else begin
         start_done_q <= 1'b0;
         collision_q  <= 1'b0;
         case (st_q)
            SPSA_ST_IDLE: begin
               if (start_req) begin
                  // Lines released; low at start aborts.
                  sda_low_q <= 1'b0;
                  scl_low_q <= 1'b0;
                  if (!sda_in || !scl_in) begin
                     collision_q <= 1'b1;
                  end else begin
                     rate_counter_q <= rate_reload_reg;
                     st_q           <= SPSA_ST_CNT1;
                  end
               end
            end
            SPSA_ST_CNT1: begin
               if (!scl_in && sda_in) begin
                  // Another master pulls SCL low here while SDA is still high.
                  collision_q <= 1'b1;
                  st_q        <= SPSA_ST_IDLE;
               end else if (!sda_in || rate_counter_q == '0) begin
                  sda_low_q      <= 1'b1;
                  rate_counter_q <= rate_reload_reg;
                  st_q           <= SPSA_ST_CNT2;
               end else begin
                  rate_counter_q <= rate_counter_q - 1'b1;
               end
            end
            SPSA_ST_CNT2: begin
               // SCL low here is not a collision.
               if (rate_counter_q == '0) begin
                  scl_low_q    <= 1'b1;
                  start_done_q <= 1'b1;
                  st_q         <= SPSA_ST_IDLE;
               end else begin
                  rate_counter_q <= rate_counter_q - 1'b1;
               end
            end
            default: st_q <= SPSA_ST_IDLE;
         endcase
      end
   end

   // Collision in first count ends the start with lines released.
   start_abort_a: assert property (
      @(posedge clk) disable iff (rst)
      (st_q == SPSA_ST_CNT1 && !scl_in && sda_in)
      |=> collision_q && st_q == SPSA_ST_IDLE && !sda_low_q)
      else $error("start not aborted on scl low");
   start_scl_a: assert property (
      @(posedge clk) disable iff (rst)
      (st_q == SPSA_ST_CNT2 && rate_counter_q == '0)
      |=> scl_low_q && start_done_q && !collision_q)
      else $error("scl not driven low at end of start");
   early_sda_a: assert property (
      @(posedge clk) disable iff (rst)
      (st_q == SPSA_ST_CNT1 && !sda_in && scl_in)
      |=> sda_low_q && st_q == SPSA_ST_CNT2)
      else $error("sda not asserted early");
   start_chk_a: assert property (
      @(posedge clk) disable iff (rst)
      (st_q == SPSA_ST_IDLE && start_req && (!sda_in || !scl_in))
      |=> collision_q && st_q == SPSA_ST_IDLE)
      else $error("start collision missed");
endmodule // spsa_start_gen

// [design/spsa_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Shift on external clock; flag after byte.
// - Works during sleep; byte received wakes device.
// - Select gating only in mode 0100.
// - Select low drives output; high releases it three clocks later (synchroniser plus register).
// - Select high or disable resets bit counter.
// - Output configured as input never transmits.
// - Either line low at start is collision.
// - Clock low while data high is collision.
// - Collision aborts, flags, returns to idle.
// - Released lines, then counter loads reload bits.
// - Data low in count: early data assert.
// - Count expiry pulls data low, reloads counter.
// - Second count ignores clock; then clock low.
module spsa_top
   import spsa_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   port_enable_bit,
   input  wire logic [3:0]             mode_sel,
   input  wire logic                   clk_polarity_bit,
   input  wire logic                   clk_edge_bit,
   input  wire logic                   sdo_as_input,
   input  wire logic                   sleep_mode,
   input  wire logic [7:0]             tx_data,
   input  wire logic                   tx_load,
   input  wire logic                   int_flag_clr,
   input  wire logic                   sck_in,
   input  wire logic                   ss_n_in,
   input  wire logic                   sdi_in,
   output logic                        sdo_out_q,
   output logic                        sdo_oe_q,
   output logic [7:0]                  rx_data_q,
   output logic                        serial_int_flag_q,
   output logic                        wake_q,
   input  wire logic                   start_req,
   input  wire logic [SPSA_RATE_W-1:0] rate_reload_reg,
   input  wire logic                   collision_clr,
   input  wire logic                   sda_in,
   input  wire logic                   scl_in,
   output logic                        sda_out_q,
   output logic                        sda_oe_q,
   output logic                        scl_out_q,
   output logic                        scl_oe_q,
   output logic                        start_done_q,
   output logic                        collision_flag_q
);
   // Two-flop synchronisers for the pin inputs.
   logic [1:0] sck_s_q, ss_s_q, sdi_s_q, sda_s_q, scl_s_q;
   logic       sck_prev_q;
   logic [2:0] arm_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_s_q    <= 2'b00;
         ss_s_q     <= 2'b11;
         sdi_s_q    <= 2'b00;
         sda_s_q    <= 2'b11;
         scl_s_q    <= 2'b11;
         sck_prev_q <= 1'b0;
         arm_q      <= 3'h0;
      end else begin
         sck_s_q    <= {sck_s_q[0], sck_in};
         ss_s_q     <= {ss_s_q[0], ss_n_in};
         sdi_s_q    <= {sdi_s_q[0], sdi_in};
         sda_s_q    <= {sda_s_q[0], sda_in};
         scl_s_q    <= {scl_s_q[0], scl_in};
         sck_prev_q <= sck_s_q[1];
         arm_q      <= {arm_q[1:0], 1'b1};
      end
   end

   logic sck_s, ss_n_s;
   logic rise, fall, lead, trail;
   logic slave_mode, ss_ctl, unit_reset, active;
   // Edge decode; polarity picks leading edge, edge bit picks shift edge.
   assign sck_s      = sck_s_q[1];
   assign ss_n_s     = ss_s_q[1];
   // Edges count only once the synchroniser holds real pin samples, so a
   // clock idling high cannot fake an edge straight after reset.
   assign rise       = arm_q[2] & sck_s & ~sck_prev_q;
   assign fall       = arm_q[2] & ~sck_s & sck_prev_q;
   assign lead       = clk_polarity_bit ? fall : rise;
   assign trail      = clk_polarity_bit ? rise : fall;
   assign slave_mode = (mode_sel == SPSA_MODE_SLAVE_SS) ||
                       (mode_sel == SPSA_MODE_SLAVE);
   assign ss_ctl     = (mode_sel == SPSA_MODE_SLAVE_SS);
   // Deselect or disable resets the unit.
   assign unit_reset = !port_enable_bit || (ss_ctl && ss_n_s);
   assign active     = slave_mode && !unit_reset;

   logic [7:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic       byte_done;
   // With edge bit set, data is sampled on the leading edge after select.
   logic       samp, drive;
   assign samp  = clk_edge_bit ? lead : trail;
   assign drive = clk_edge_bit ? trail : lead;
   assign byte_done = active && samp && bit_cnt_q == 3'(SPSA_BYTE_BITS-1);

   // Shift register and bit counter, driven by the external clock.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_q   <= SPSA_SHIFT_RST;
         bit_cnt_q <= SPSA_CNT_RST;
         rx_data_q <= SPSA_SHIFT_RST;
      end else if (unit_reset) begin
         bit_cnt_q <= SPSA_CNT_RST;
         if (tx_load) shift_q <= tx_data;
      end else if (tx_load && bit_cnt_q == SPSA_CNT_RST) begin
         shift_q <= tx_data;
      end else if (active && samp) begin
         shift_q   <= {shift_q[6:0], sdi_s_q[1]};
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (byte_done) rx_data_q <= {shift_q[6:0], sdi_s_q[1]};
      end
   end

   // Output pin: driven only while active and not set as input; released on the next clock otherwise.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdo_out_q <= 1'b0;
         sdo_oe_q  <= 1'b0;
      end else begin
         sdo_oe_q <= active && !sdo_as_input;
         if (active && (drive || bit_cnt_q == SPSA_CNT_RST)) begin
            sdo_out_q <= shift_q[7];
         end
      end
   end

   // Byte flag: set wins over clear; wake pulses when asleep.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_int_flag_q <= 1'b0;
         wake_q            <= 1'b0;
      end else begin
         if (byte_done) serial_int_flag_q <= 1'b1;
         else if (int_flag_clr) serial_int_flag_q <= 1'b0;
         wake_q <= byte_done && sleep_mode;
      end
   end

   logic sda_low, scl_low, coll_p;
   spsa_start_gen u_start (
      .clk             (clk),
      .rst             (rst),
      .start_req       (start_req),
      .rate_reload_reg (rate_reload_reg),
      .sda_in          (sda_s_q[1]),
      .scl_in          (scl_s_q[1]),
      .sda_low_q       (sda_low),
      .scl_low_q       (scl_low),
      .start_done_q    (start_done_q),
      .collision_q     (coll_p)
   );

   // Open-drain pins; sticky collision flag, set wins.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_out_q        <= 1'b0;
         sda_oe_q         <= 1'b0;
         scl_out_q        <= 1'b0;
         scl_oe_q         <= 1'b0;
         collision_flag_q <= 1'b0;
      end else begin
         sda_oe_q  <= sda_low;
         scl_oe_q  <= scl_low;
         if (coll_p) collision_flag_q <= 1'b1;
         else if (collision_clr) collision_flag_q <= 1'b0;
      end
   end

   // Slave side checks: pin enable, bit counter, flags and wake.
   sdo_release_a: assert property (
      @(posedge clk) disable iff (rst)
      (ss_ctl && ss_n_s && port_enable_bit) |=> !sdo_oe_q)
      else $error("output driven while deselected");
   sdo_drive_a: assert property (
      @(posedge clk) disable iff (rst)
      (active && !sdo_as_input) |=> sdo_oe_q)
      else $error("output not driven while selected");
   cnt_reset_a: assert property (
      @(posedge clk) disable iff (rst)
      unit_reset |=> bit_cnt_q == 3'h0)
      else $error("bit counter not cleared");
   byte_flag_a: assert property (
      @(posedge clk) disable iff (rst)
      byte_done |=> serial_int_flag_q && bit_cnt_q == 3'h0)
      else $error("byte flag missing");
   flag_hold_a: assert property (
      @(posedge clk) disable iff (rst)
      (serial_int_flag_q && !int_flag_clr) |=> serial_int_flag_q)
      else $error("byte flag dropped");
   rx_hold_a: assert property (
      @(posedge clk) disable iff (rst)
      !byte_done |=> $stable(rx_data_q))
      else $error("received byte changed without a byte");
   sleep_wake_a: assert property (
      @(posedge clk) disable iff (rst)
      (byte_done && sleep_mode) |=> wake_q)
      else $error("no wake on byte");
   wake_sleep_a: assert property (
      @(posedge clk) disable iff (rst)
      !sleep_mode |=> !wake_q)
      else $error("wake pulse outside sleep");
   sdo_input_a: assert property (
      @(posedge clk) disable iff (rst)
      sdo_as_input |=> !sdo_oe_q)
      else $error("output driven while configured as input");

   // Start side checks: pin enables follow the generator, flag is sticky.
   sda_pin_a: assert property (
      @(posedge clk) disable iff (rst)
      sda_low |=> sda_oe_q)
      else $error("sda pin not pulled low");
   scl_pin_a: assert property (
      @(posedge clk) disable iff (rst)
      scl_low |=> scl_oe_q)
      else $error("scl pin not pulled low");
   coll_sticky_a: assert property (
      @(posedge clk) disable iff (rst)
      (collision_flag_q && !collision_clr) |=> collision_flag_q)
      else $error("collision flag dropped");
endmodule // spsa_top

// [verif/spsa_peer_model.sv]
`timescale 1ns/1ps
// Stand-in for the outside SPI master and the other I2C masters.
module spsa_peer_model (
   input  wire logic clk_polarity_bit,
   input  wire logic sdo_out_q,
   input  wire logic sdo_oe_q,
   input  wire logic sda_oe_q,
   input  wire logic scl_oe_q,
   output logic      sck_in,
   output logic      ss_n_in,
   output logic      sdi_in,
   output logic      sda_in,
   output logic      scl_in
);
   logic sda_pull;
   logic scl_pull;
   logic sck_act;
   logic last_q;
   logic sdo_line;
   // A released output floats, so it shows the inverse of its last level.
   always @(sdo_oe_q or sdo_out_q) begin
      if (sdo_oe_q === 1'b1) last_q = sdo_out_q;
   end
   assign sdo_line = (sdo_oe_q === 1'b1) ? sdo_out_q : ~last_q;
   // Open-drain lines are low while any master pulls them.
   assign sda_in = ~(sda_oe_q | sda_pull);
   assign scl_in = ~(scl_oe_q | scl_pull);
   // The clock idles at the polarity level; sck_act marks the active phase.
   assign sck_in = sck_act ^ clk_polarity_bit;
   initial begin
      {sck_act, sdi_in, sda_pull, scl_pull, last_q} = '0;
      ss_n_in = 1'b1;
   end
   // One frame, MSB first; the clock stands still between frames.
   task automatic xfer(input logic [7:0] tx, input int nb,
                       input logic sel, output logic [7:0] rx);
      ss_n_in = ~sel;
      #160;
      for (int i = 7; i > 7 - nb; i--) begin
         #40 sdi_in = tx[i];
         #40 sck_act = 1'b1;
         rx[i] = sdo_line;
         #80 sck_act = 1'b0;
      end
      #160 ss_n_in = 1'b1;
      sdi_in = ~sdi_in;
   endtask
endmodule // spsa_peer_model

// [verif/spsa_top_tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench for the serial port block.
module spsa_top_tb_top;
   import spsa_pkg::*;
   logic clk, rst, port_enable_bit, clk_polarity_bit, clk_edge_bit;
   logic sdo_as_input, sleep_mode, tx_load, int_flag_clr, start_req;
   logic collision_clr, sck_in, ss_n_in, sdi_in, sda_in, scl_in;
   logic [3:0] mode_sel;
   logic [7:0] tx_data, rx_data_q;
   logic [6:0] rate_reload_reg;
   logic sdo_out_q, sdo_oe_q, serial_int_flag_q, wake_q, sda_out_q;
   logic sda_oe_q, scl_out_q, scl_oe_q, start_done_q, collision_flag_q;
   logic oe_seen, wake_seen;
   int   fails, n_tests;
   int   cyc = 0;
   spsa_top u_spsa_top (
      .clk, .rst, .port_enable_bit, .mode_sel, .clk_polarity_bit,
      .clk_edge_bit, .sdo_as_input, .sleep_mode, .tx_data, .tx_load,
      .int_flag_clr, .sck_in, .ss_n_in, .sdi_in, .sdo_out_q, .sdo_oe_q,
      .rx_data_q, .serial_int_flag_q, .wake_q, .start_req,
      .rate_reload_reg, .collision_clr, .sda_in, .scl_in, .sda_out_q,
      .sda_oe_q, .scl_out_q, .scl_oe_q, .start_done_q, .collision_flag_q
   );
   spsa_peer_model u_spsa_peer_model (
      .clk_polarity_bit,
      .sdo_out_q, .sdo_oe_q, .sda_oe_q, .scl_oe_q, .sck_in, .ss_n_in,
      .sdi_in, .sda_in, .scl_in
   );
   // System clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Sticky monitors catch one-cycle pulses; the ceiling cuts a hang.
   always @(posedge clk) begin
      if (sdo_oe_q === 1'b1) oe_seen <= 1'b1;
      if (wake_q === 1'b1) wake_seen <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         results;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic clear;
      int_flag_clr = 1'b1;
      collision_clr = 1'b1;
      tick(1);
      {int_flag_clr, collision_clr} = '0;
      tick(1);
   endtask
   task automatic reboot;
      rst = 1'b1;
      {u_spsa_peer_model.sda_pull, u_spsa_peer_model.scl_pull} = '0;
      tick(2);
      rst = 1'b0;
      tick(4);
   endtask
   // Load the slave, let the master shift a frame, return its byte.
   task automatic spi(input logic [7:0] st, input logic [7:0] mt,
                      input int nb, input logic sel, output logic [7:0] mr);
      tx_data = st;
      tx_load = 1'b1;
      tick(1);
      tx_load = 1'b0;
      {oe_seen, wake_seen} = '0;
      u_spsa_peer_model.xfer(mt, nb, sel, mr);
      tick(6);
   endtask
   task automatic t_spi;
      logic [7:0] mr;
      spi(8'ha5, 8'h3c, 8, 1'b1, mr);
      check(mr, 8'ha5);
      check(rx_data_q, 8'h3c);
      check(serial_int_flag_q, 8'h01);
      check(oe_seen, 8'h01);
      check(wake_seen, 8'h00);
      clear;
      check(serial_int_flag_q, 8'h00);
      // Deselect after half a byte drops it and rewinds the counter.
      spi(8'h81, 8'hf0, 4, 1'b1, mr);
      check(sdo_oe_q, 8'h00);
      check(serial_int_flag_q, 8'h00);
      spi(8'h5a, 8'hc3, 8, 1'b1, mr);
      check(rx_data_q, 8'hc3);
      check(mr, 8'h5a);
      clear;
      spi(8'h00, 8'h99, 8, 1'b0, mr);
      check(serial_int_flag_q, 8'h00);
      check(oe_seen, 8'h00);
      // Without select control the edge bit must be clear.
      mode_sel = SPSA_MODE_SLAVE;
      clk_edge_bit = 1'b0;
      sleep_mode = 1'b1;
      sdo_as_input = 1'b1;
      spi(8'hff, 8'h96, 3, 1'b0, mr);
      port_enable_bit = 1'b0;
      tick(2);
      port_enable_bit = 1'b1;
      spi(8'hff, 8'h69, 8, 1'b0, mr);
      check(rx_data_q, 8'h69);
      check(wake_seen, 8'h01);
      check(oe_seen, 8'h00);
      // Polarity changes only while disabled, so the clock idles first.
      port_enable_bit = 1'b0;
      clk_polarity_bit = 1'b1;
      mode_sel = SPSA_MODE_SLAVE_SS;
      clk_edge_bit = 1'b1;
      {sleep_mode, sdo_as_input} = '0;
      tick(4);
      port_enable_bit = 1'b1;
      clear;
      spi(8'hc3, 8'h5a, 8, 1'b1, mr);
      check(mr, 8'hc3);
      check(rx_data_q, 8'h5a);
      check(serial_int_flag_q, 8'h01);
      // A clock idling high across reset must not count as an edge.
      mode_sel = SPSA_MODE_SLAVE;
      clk_edge_bit = 1'b0;
      reboot;
      spi(8'h00, 8'ha6, 8, 1'b0, mr);
      check(rx_data_q, 8'ha6);
   endtask
   // Start with other masters pulling a line at the given cycles.
   task automatic start(input logic [6:0] r, input int sa, input int sc,
                        output int t_sda, output int t_done);
      if (sa == 0) u_spsa_peer_model.sda_pull = 1'b1;
      tick(3);
      rate_reload_reg = r;
      start_req = 1'b1;
      tick(1);
      start_req = 1'b0;
      t_sda = -1;
      t_done = -1;
      for (int k = 1; k < 300; k++) begin
         if (k == sa) u_spsa_peer_model.sda_pull = 1'b1;
         if (k == sc) u_spsa_peer_model.scl_pull = 1'b1;
         tick(1);
         if (t_sda < 0 && sda_oe_q === 1'b1) t_sda = k;
         if (start_done_q === 1'b1) t_done = k;
         if (t_done > 0 || collision_flag_q === 1'b1) break;
      end
      {u_spsa_peer_model.sda_pull, u_spsa_peer_model.scl_pull} = '0;
      tick(5);
   endtask
   task automatic t_start;
      int a;
      int d;
      reboot;
      start(7'h03, 99, 6, a, d);
      check(8'(a), 8'h05);
      check(8'(d), 8'h08);
      check(collision_flag_q, 8'h00);
      check(scl_oe_q, 8'h01);
      check({sda_out_q, scl_out_q}, 8'h00);
      // A finished Start keeps both lines low; reset frees them.
      reboot;
      start(7'h14, 5, 99, a, d);
      check(8'(a > 5 && a < 21), 8'h01);
      reboot;
      start(7'h03, 0, 99, a, d);
      check(8'(a), 8'hff);
      check(collision_flag_q, 8'h01);
      clear;
      check(collision_flag_q, 8'h00);
      start(7'h03, 99, 99, a, d);
      check(8'(a), 8'h05);
      reboot;
      start(7'h0a, 99, 2, a, d);
      check(8'(a), 8'hff);
      check(collision_flag_q, 8'h01);
   endtask
   task automatic results;
      $display("fails %0d, n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Quiet inputs, hold reset six cycles, then run the scenarios.
   initial begin
      rst = 1'b1;
      {port_enable_bit, clk_polarity_bit, sdo_as_input, sleep_mode} = '0;
      {tx_load, int_flag_clr, start_req, collision_clr, tx_data} = '0;
      {rate_reload_reg, fails, n_tests, oe_seen, wake_seen} = '0;
      mode_sel = SPSA_MODE_SLAVE_SS;
      clk_edge_bit = 1'b1;
      port_enable_bit = 1'b1;
      tick(6);
      rst = 1'b0;
      tick(2);
      t_spi;
      t_start;
      results;
   end
endmodule // spsa_top_tb_top
